// ### hdl/hic_regs_top.sv
// Summary of operation
// - 16-bit vendor identifier, low byte at 00h, high byte at 01h, reported whole.
// - 16-bit product identifier, low byte at 02h, high byte at 03h, reported whole.
// - 16-bit BCD release number, low byte at 04h, high byte at 05h.
// - every identifier byte is fully writable over the serial configuration port.
// - bit 7 of configuration byte one: 0 bus-powered, 1 self-powered.
// - configuration byte one resets to self-powered, ganged port power.
// - a register never written keeps its built-in default.
`timescale 1ns/100ps
`default_nettype none

module hic_regs_top
  import hic_pkg::*;
#(
  // identification defaults: values are arbitrary
  parameter logic [7:0] VID_LO_DEF = 8'h5A,
  parameter logic [7:0] VID_HI_DEF = 8'h1E,
  parameter logic [7:0] PID_LO_DEF = 8'h01,
  parameter logic [7:0] PID_HI_DEF = 8'h10,
  parameter logic [7:0] REL_LO_DEF = 8'h00,
  parameter logic [7:0] REL_HI_DEF = 8'h01,
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEF
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // serial slave port
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // configuration seen by the hub core
  output logic      [15:0] vendorId,
  output logic      [15:0] productId,
  output logic      [15:0] releaseNumber,
  output logic      [7:0]  cfgByteOne,
  output logic             selfPowered
);

  localparam logic [7:0] RST_TABLE [0:6] = '{VID_LO_DEF, VID_HI_DEF, PID_LO_DEF,
                                              PID_HI_DEF, REL_LO_DEF, REL_HI_DEF,
                                              CFG_ONE_RST};

  logic       sclF;
  logic       sdaF;
  hic_state_t state_r;
  hic_state_t state_nxt;
  logic [3:0] bitCnt_r;
  logic [3:0] bitCnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic       rw_r;
  logic       rw_nxt;
  logic       nack_r;
  logic       nack_nxt;
  logic       sdaOe_r;
  logic       sdaOe_nxt;
  logic       sclPrev_r;
  logic       sdaPrev_r;
  logic       sdaOut_r;
  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic       wrEn;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic [7:0] rdData;
  logic [7:0] regs_r   [0:6];
  logic [7:0] regs_nxt [0:6];

  function automatic logic regValid(input logic [7:0] idx);
    regValid = (idx < REG_COUNT);
  endfunction

  // unmapped offsets read as zero
  function automatic logic [7:0] regRead(input logic [7:0] idx,
                                         input logic [7:0] file [0:6]);
    regRead = 8'h00;
    if (regValid(idx))
    begin
      regRead = file[idx[2:0]];
    end
  endfunction

  hic_pin_sync #(
    .W (2)
  ) u_pin_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pinIn    ({sclIn, sdaIn}),
    .pinLevel ({sclF, sdaF})
  );

  assign sclRise   = sclF & ~sclPrev_r;
  assign sclFall   = ~sclF & sclPrev_r;
  assign startSeen = sclF & sclPrev_r & sdaPrev_r & ~sdaF;
  assign stopSeen  = sclF & sclPrev_r & ~sdaPrev_r & sdaF;
  assign rdData    = regRead(ptr_r, regs_r);

  // serial protocol
  always_comb
  begin
    state_nxt  = state_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt  = shift_r;
    ptr_nxt    = ptr_r;
    rw_nxt     = rw_r;
    nack_nxt   = nack_r;
    sdaOe_nxt  = sdaOe_r;
    wrEn       = 1'b0;
    wrAddr     = ptr_r;
    wrData     = shift_r;
    if (stopSeen)
    begin
      state_nxt = ST_IDLE;
      sdaOe_nxt = 1'b0;
    end
    else if (startSeen)
    begin
      state_nxt  = ST_ADDR;
      bitCnt_nxt = 4'h0;
      sdaOe_nxt  = 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          sdaOe_nxt = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WDATA:
        begin
          if (sclRise && bitCnt_r != BYTE_BITS)
          begin
            shift_nxt  = {shift_r[6:0], sdaF};
            bitCnt_nxt = bitCnt_r + 4'h1;
          end
          else if (sclFall && bitCnt_r == BYTE_BITS)
          begin
            bitCnt_nxt = 4'h0;
            sdaOe_nxt  = 1'b1;
            if (state_r == ST_ADDR)
            begin
              // foreign address: stay off the bus until the next start
              if (shift_r[7:1] == SLAVE_ADDR)
              begin
                rw_nxt    = shift_r[0];
                state_nxt = ST_ADDR_ACK;
              end
              else
              begin
                sdaOe_nxt = 1'b0;
                state_nxt = ST_IDLE;
              end
            end
            else if (state_r == ST_PTR)
            begin
              ptr_nxt   = shift_r;
              state_nxt = ST_PTR_ACK;
            end
            else
            begin
              wrEn      = 1'b1;
              ptr_nxt   = ptr_r + 8'h01;
              state_nxt = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (sclFall)
          begin
            if (rw_r)
            begin
              shift_nxt = rdData;
              sdaOe_nxt = ~rdData[7];
              ptr_nxt   = ptr_r + 8'h01;
              state_nxt = ST_RDATA;
            end
            else
            begin
              sdaOe_nxt = 1'b0;
              state_nxt = ST_PTR;
            end
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK:
        begin
          if (sclFall)
          begin
            sdaOe_nxt = 1'b0;
            state_nxt = ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (sclRise)
          begin
            bitCnt_nxt = bitCnt_r + 4'h1;
          end
          else if (sclFall)
          begin
            if (bitCnt_r == BYTE_BITS)
            begin
              sdaOe_nxt  = 1'b0;
              bitCnt_nxt = 4'h0;
              state_nxt  = ST_RDATA_ACK;
            end
            else
            begin
              shift_nxt = {shift_r[6:0], 1'b0};
              sdaOe_nxt = ~shift_r[6];
            end
          end
        end
        ST_RDATA_ACK:
        begin
          if (sclRise)
          begin
            nack_nxt = sdaF;
          end
          else if (sclFall)
          begin
            if (nack_r)
            begin
              state_nxt = ST_IDLE;
            end
            else
            begin
              shift_nxt = rdData;
              sdaOe_nxt = ~rdData[7];
              ptr_nxt   = ptr_r + 8'h01;
              state_nxt = ST_RDATA;
            end
          end
        end
        default:
        begin
          sdaOe_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r   <= ST_IDLE;
      bitCnt_r  <= 4'h0;
      shift_r   <= 8'h00;
      ptr_r     <= 8'h00;
      rw_r      <= 1'b0;
      nack_r    <= 1'b0;
      sdaOe_r   <= 1'b0;
      sclPrev_r <= PIN_IDLE;
      sdaPrev_r <= PIN_IDLE;
      sdaOut_r  <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      bitCnt_r  <= bitCnt_nxt;
      shift_r   <= shift_nxt;
      ptr_r     <= ptr_nxt;
      rw_r      <= rw_nxt;
      nack_r    <= nack_nxt;
      sdaOe_r   <= sdaOe_nxt;
      sclPrev_r <= sclF;
      sdaPrev_r <= sdaF;
      sdaOut_r  <= 1'b0;
    end
  end

  // register file; writes past the last offset are acked and dropped
  always_comb
  begin
    regs_nxt = regs_r;
    if (wrEn && regValid(wrAddr))
    begin
      regs_nxt[wrAddr[2:0]] = wrData;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      regs_r <= RST_TABLE;
    end
    else
    begin
      regs_r <= regs_nxt;
    end
  end

  assign sdaOut        = sdaOut_r;
  assign sdaOe         = sdaOe_r;
  assign vendorId      = {regs_r[OFS_VID_HI[2:0]], regs_r[OFS_VID_LO[2:0]]};
  assign productId     = {regs_r[OFS_PID_HI[2:0]], regs_r[OFS_PID_LO[2:0]]};
  assign releaseNumber = {regs_r[OFS_REL_HI[2:0]], regs_r[OFS_REL_LO[2:0]]};
  assign cfgByteOne    = regs_r[OFS_CFG_ONE[2:0]];
  assign selfPowered   = regs_r[OFS_CFG_ONE[2:0]][CFG_ONE_PWR_BIT];

  logic postRst_r;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      postRst_r <= 1'b0;
    end
    else
    begin
      postRst_r <= 1'b1;
    end
  end

  chk_vendor_low_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wrEn && wrAddr == OFS_VID_LO) |=> (vendorId[7:0] == $past(wrData)))
    else $error("vendor id low byte not updated");

  chk_product_high_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wrEn && wrAddr == OFS_PID_HI) |=> (productId[15:8] == $past(wrData))
      && $stable(productId[7:0]))
    else $error("product id high byte not updated");

  chk_release_low_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wrEn && wrAddr == OFS_REL_LO) |=> (releaseNumber[7:0] == $past(wrData))
      && $stable(releaseNumber[15:8]))
    else $error("release number low byte not updated");

  chk_write_acked: assert property (@(posedge core_clk) disable iff (sys_rst)
    wrEn |=> sdaOe && state_r == ST_WDATA_ACK)
    else $error("written byte not acknowledged");

  chk_power_select: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wrEn && wrAddr == OFS_CFG_ONE) |=> (selfPowered == $past(wrData[7])))
    else $error("power select does not follow written bit");

  chk_cfg_reset_value: assert property (@(posedge core_clk) disable iff (sys_rst)
    !postRst_r |-> (cfgByteOne == CFG_ONE_RST) && selfPowered)
    else $error("configuration byte one reset value wrong");

  chk_unwritten_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !wrEn |=> $stable(vendorId) && $stable(productId) && $stable(releaseNumber)
      && $stable(cfgByteOne))
    else $error("register changed without a write");

  chk_past_end_dropped: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wrEn && !regValid(wrAddr)) |=> $stable(vendorId) && $stable(productId)
      && $stable(releaseNumber) && $stable(cfgByteOne))
    else $error("write past the last offset changed a register");

  chk_read_returns: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_r == ST_ADDR_ACK && sclFall && rw_r && !stopSeen && !startSeen)
      |=> (shift_r == $past(rdData)) && state_r == ST_RDATA && (sdaOe == ~shift_r[7]))
    else $error("read data is not the stored register value");

endmodule

`default_nettype wire

// ### hdl/hic_pkg.sv
package hic_pkg;

  // register offsets on the serial slave port
  localparam logic [7:0] OFS_VID_LO  = 8'h00;
  localparam logic [7:0] OFS_VID_HI  = 8'h01;
  localparam logic [7:0] OFS_PID_LO  = 8'h02;
  localparam logic [7:0] OFS_PID_HI  = 8'h03;
  localparam logic [7:0] OFS_REL_LO  = 8'h04;
  localparam logic [7:0] OFS_REL_HI  = 8'h05;
  localparam logic [7:0] OFS_CFG_ONE = 8'h06;
  localparam logic [7:0] REG_COUNT   = 8'h07;

  // first configuration byte
  localparam logic [7:0] CFG_ONE_RST     = 8'h98;
  localparam int         CFG_ONE_PWR_BIT = 7;

  // serial framing
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h2D;

  // pin level while the bus is idle
  localparam logic       PIN_IDLE    = 1'b1;

  // gray coded along the write path and the read data loop; ST_ADDR_ACK to ST_RDATA is not
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_PTR       = 4'h2,
    ST_PTR_ACK   = 4'h6,
    ST_WDATA     = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA     = 4'h4,
    ST_RDATA_ACK = 4'hC
  } hic_state_t;

endpackage

// ### hdl/hic_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module hic_pin_sync
  import hic_pkg::*;
#(
  parameter int W = 2
)
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // raw pins and filtered levels
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinLevel
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage3_r;
  logic [W-1:0] level_r;
  logic [W-1:0] level_nxt;

  // a change counts only once the second and third stages agree
  always_comb
  begin
    level_nxt = level_r;
    for (int i = 0; i < W; i++)
    begin
      if (stage2_r[i] == stage3_r[i])
      begin
        level_nxt[i] = stage3_r[i];
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage1_r <= {W{PIN_IDLE}};
      stage2_r <= {W{PIN_IDLE}};
      stage3_r <= {W{PIN_IDLE}};
      level_r  <= {W{PIN_IDLE}};
    end
    else
    begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      level_r  <= level_nxt;
    end
  end

  assign pinLevel = level_r;

endmodule

`default_nettype wire

// ### tb/hic_cfg_master.sv
`timescale 1ns/100ps
`default_nettype none

module hic_cfg_master
(
  // clock
  input  wire logic core_clk,
  // resolved data wire, master pins
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaLow
);

  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  // one phase is 10 clocks, above the 8 the slave needs
  task automatic q;
    repeat (10) @(negedge core_clk);
  endtask

  // also serves as repeated start from clock low
  task automatic start_cond;
    sdaLow = 1'b0;
    q;
    scl = 1'b1;
    q;
    sdaLow = 1'b1;
    q;
    scl = 1'b0;
    q;
  endtask

  task automatic stop_cond;
    sdaLow = 1'b1;
    q;
    scl = 1'b1;
    q;
    sdaLow = 1'b0;
    q;
  endtask

  task automatic put_bit(input logic b);
    sdaLow = ~b;
    q;
    scl = 1'b1;
    q;
    scl = 1'b0;
    q;
  endtask

  // sampled late in the high phase, after the slave settles
  task automatic get_bit(output logic b);
    sdaLow = 1'b0;
    q;
    scl = 1'b1;
    q;
    b = sdaLine;
    scl = 1'b0;
    q;
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int k = 7; k >= 0; k--) put_bit(d[k]);
    get_bit(a);
    ack = ~a;
  endtask

  task automatic get_byte(output logic [7:0] d, input logic nack);
    for (int k = 7; k >= 0; k--) get_bit(d[k]);
    put_bit(nack);
  endtask

  // writes only what the caller asks
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d,
                           output logic ok);
    logic a0, a1, a2;
    start_cond;
    put_byte({dev, 1'b0}, a0);
    put_byte(ofs, a1);
    put_byte(d, a2);
    stop_cond;
    ok = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] d,
                          output logic ok);
    logic a0, a1, a2;
    start_cond;
    put_byte({dev, 1'b0}, a0);
    put_byte(ofs, a1);
    start_cond;
    put_byte({dev, 1'b1}, a2);
    get_byte(d, 1'b1);
    stop_cond;
    ok = a0 & a1 & a2;
  endtask

  // two bytes in one read: ack the first, nack the second
  task automatic read_pair(input logic [6:0] dev, input logic [7:0] ofs, output logic [15:0] d,
                           output logic ok);
    logic a0, a1, a2;
    start_cond;
    put_byte({dev, 1'b0}, a0);
    put_byte(ofs, a1);
    start_cond;
    put_byte({dev, 1'b1}, a2);
    get_byte(d[7:0], 1'b0);
    get_byte(d[15:8], 1'b1);
    stop_cond;
    ok = a0 & a1 & a2;
  endtask

endmodule

`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import hic_pkg::*;
;

  // identification defaults: values are arbitrary, except the top byte, which is the configuration byte one reset value 98h
  localparam logic [55:0] DEFS = {8'h98, 8'h62, 8'h17, 8'h4B, 8'hC3, 8'h29, 8'h7E};
  localparam logic [6:0]  DEV  = 7'h2D;

  logic        core_clk;
  logic        sys_rst;
  logic        scl;
  logic        mLow;
  logic        sdaLine;
  logic        sdaOut;
  logic        sdaOe;
  logic [15:0] vendorId;
  logic [15:0] productId;
  logic [15:0] releaseNumber;
  logic [7:0]  cfgByteOne;
  logic        selfPowered;
  logic [7:0]  shadow [7];
  logic [7:0]  rd;
  logic [15:0] pair;
  logic        ok;
  int          mismatches;
  int          n_compared;

  // pulled up unless someone pulls low
  assign sdaLine = (sdaOe ? sdaOut : 1'b1) & ~mLow;

  always #5 core_clk = ~core_clk;

  hic_regs_top #(
    .VID_LO_DEF (DEFS[7:0]),
    .VID_HI_DEF (DEFS[15:8]),
    .PID_LO_DEF (DEFS[23:16]),
    .PID_HI_DEF (DEFS[31:24]),
    .REL_LO_DEF (DEFS[39:32]),
    .REL_HI_DEF (DEFS[47:40]),
    .SLAVE_ADDR (DEV)
  ) DUT (
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .sclIn         (scl),
    .sdaIn         (sdaLine),
    .sdaOut        (sdaOut),
    .sdaOe         (sdaOe),
    .vendorId      (vendorId),
    .productId     (productId),
    .releaseNumber (releaseNumber),
    .cfgByteOne    (cfgByteOne),
    .selfPowered   (selfPowered)
  );

  hic_cfg_master master (
    .core_clk (core_clk),
    .sdaLine  (sdaLine),
    .scl      (scl),
    .sdaLow   (mLow)
  );

  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check_val(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  task automatic reset_dut;
    @(negedge core_clk);
    sys_rst = 1'b1;
    repeat (6) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int k = 0; k < 7; k++) shadow[k] = DEFS[k*8 +: 8];
    repeat (8) @(negedge core_clk);
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    master.write_reg(DEV, ofs, d, ok);
    check_val({15'h0000, ok}, 16'h0001);
    shadow[ofs[2:0]] = d;
  endtask

  task automatic check_all;
    check_val(vendorId, {shadow[1], shadow[0]});
    check_val(productId, {shadow[3], shadow[2]});
    check_val(releaseNumber, {shadow[5], shadow[4]});
    check_val({15'h0000, selfPowered}, {15'h0000, shadow[6][7]});
    for (int k = 0; k < 7; k++)
    begin
      master.read_reg(DEV, k[7:0], rd, ok);
      check_val({15'h0000, ok}, 16'h0001);
      check_val({8'h00, rd}, {8'h00, shadow[k]});
    end
  endtask

  initial
  begin
    repeat (80000) @(posedge core_clk);
    mismatches++;
    print_verdict;
  end

  initial
  begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    mismatches = 0;
    n_compared = 0;
    reset_dut;
    check_val({8'h00, cfgByteOne}, 16'h0098);
    check_all;
    for (int i = 0; i < 6; i++) wr(i[7:0], 8'hA5 ^ i[7:0]);
    check_all;
    check_val({8'h00, cfgByteOne}, {8'h00, DEFS[55:48]});
    // complement pass toggles every bit of every identifier byte
    for (int i = 0; i < 6; i++) wr(i[7:0], ~(8'hA5 ^ i[7:0]));
    check_all;
    // burst read: master acks the first byte, pointer runs on
    master.read_pair(DEV, OFS_PID_LO, pair, ok);
    check_val({15'h0000, ok}, 16'h0001);
    check_val(pair, {shadow[3], shadow[2]});
    // bus powered, reserved bits left at their defaults
    wr(8'h06, 8'h18);
    check_all;
    check_val({15'h0000, selfPowered}, 16'h0000);
    master.write_reg(DEV ^ 7'h01, 8'h00, 8'h00, ok);
    check_val({15'h0000, ok}, 16'h0000);
    check_val(vendorId, {shadow[1], shadow[0]});
    // past the last offset: acked, dropped, reads as zero
    master.write_reg(DEV, REG_COUNT, 8'h5C, ok);
    check_val({15'h0000, ok}, 16'h0001);
    check_val({8'h00, cfgByteOne}, {8'h00, shadow[6]});
    master.read_reg(DEV, REG_COUNT, rd, ok);
    check_val({8'h00, rd}, 16'h0000);
    reset_dut;
    check_val({8'h00, cfgByteOne}, 16'h0098);
    check_all;
    print_verdict;
  end

endmodule

`default_nettype wire
